// ---- src/rpc_defs.vh ----
/*
 * register indices, field positions, reset values and timing counts
 * of the real-time counter and periodic tick block.
 * assumes: included by bare name into every design file that needs it.
 */
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH

// register indices; byte address is four times the index
`define RPC_IDX_CTL        6'h00
`define RPC_IDX_STATUS     6'h01
`define RPC_IDX_INTEN      6'h02
`define RPC_IDX_FLAGS      6'h03
`define RPC_IDX_TEMP       6'h04
`define RPC_IDX_DBG        6'h05
`define RPC_IDX_TRIM       6'h06
`define RPC_IDX_SRC        6'h07
`define RPC_IDX_COUNT      6'h08
`define RPC_IDX_TOP        6'h0A
`define RPC_IDX_CMP        6'h0C
`define RPC_IDX_TCTRL      6'h10
`define RPC_IDX_TSTATUS    6'h11
`define RPC_IDX_TINTEN     6'h12
`define RPC_IDX_TINTFLAGS  6'h13
`define RPC_IDX_TDBG       6'h15

// control_a fields
`define RPC_CA_STDBY       7
`define RPC_CA_PRESC_HI    6
`define RPC_CA_PRESC_LO    3
`define RPC_CA_CORR        2
`define RPC_CA_ON          0
`define RPC_CA_MASK        8'hFD

// calibration fields
`define RPC_CAL_SIGN       7
`define RPC_CAL_ERR_HI     6

// tick_control fields
`define RPC_TC_PER_HI      6
`define RPC_TC_PER_LO      3
`define RPC_TC_ON          0
`define RPC_TC_MASK        8'h79

// irq flag / enable bit positions
`define RPC_IRQ_WRAP       0
`define RPC_IRQ_MATCH      1
`define RPC_IRQ_TICK       0

// reset values
`define RPC_RST_8          8'h00
`define RPC_RST_CNT        16'h0000
`define RPC_RST_TOP        16'hFFFF
`define RPC_RST_CMP        16'h0000

// timing
`define RPC_SYNC_TICKS     2
`define RPC_CORR_INTERVAL  20'hF_4240
`define RPC_EVT_TOP_BIT    12

`endif

// ---- src/rpc_sync_slot.v ----
/*
 * one write-crossing tracker: holds a pending flag from a register write
 * until the given number of slow-clock edges has passed, then pulses apply.
 * assumes: slowTick is a one-cycle pulse on mclk at each slow-clock edge.
 */
`timescale 1ns/1ns
`include "rpc_defs.vh"

module rpc_sync_slot #(
  parameter TICKS = `RPC_SYNC_TICKS
) (
  input  wire mclk,
  input  wire sys_rst,
  input  wire load,
  input  wire slowTick,
  output reg  pending_q,
  output reg  apply_q
);

  reg [3:0] cnt_q;

  // count slow edges while pending, apply after the last one
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
      apply_q   <= 1'b0;
      cnt_q     <= 4'h0;
    end else begin
      apply_q <= 1'b0;
      if (load) begin
        pending_q <= 1'b1;
        cnt_q     <= 4'h0;
      end else if (pending_q && slowTick) begin
        if (cnt_q == TICKS[3:0] - 4'h1) begin
          pending_q <= 1'b0;
          apply_q   <= 1'b1;
        end
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule // rpc_sync_slot

// ---- src/rpc_prescaler.v ----
/*
 * shared 15-bit prescaler with crystal error correction.
 * assumes: slowTick pulses once per slow-clock edge; the counter step
 * output is combinational and valid in the cycle of slowTick.
 */
`timescale 1ns/1ns
`include "rpc_defs.vh"

module rpc_prescaler #(
  parameter [19:0] INTERVAL = `RPC_CORR_INTERVAL
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        slowTick,
  input  wire        run,
  input  wire        corrOn,
  input  wire        corrSign,
  input  wire [6:0]  corrErr,
  input  wire [3:0]  divSel,
  output reg  [14:0] presc_q,
  output wire        countStep
);

  reg  [19:0] ivl_q;
  reg  [19:0] acc_q;
  reg         corrAct_q;
  wire [19:0] accSum  = acc_q + {13'h0000, corrErr};
  wire        corrHit = corrAct_q && (accSum >= INTERVAL);
  // slow: hold one cycle; fast: advance two cycles
  wire [1:0]  inc     = !corrHit ? 2'd1 : (corrSign ? 2'd2 : 2'd0);
  wire [14:0] mask    = (15'h0001 << divSel) - 15'h0001;
  wire [15:0] lowSum  = {1'b0, presc_q & mask} + {14'h0000, inc};

  // counter advances when the low bits carry past the divider mask
  assign countStep = (lowSum > {1'b0, mask});

  // prescaler restarts from zero whenever both functions are off
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= 15'h0000;
    end else if (!run) begin
      presc_q <= 15'h0000;
    end else if (slowTick) begin
      presc_q <= presc_q + {13'h0000, inc};
    end
  end

  // interval and spread accumulator; an interval in flight finishes
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ivl_q     <= 20'h0_0000;
      acc_q     <= 20'h0_0000;
      corrAct_q <= 1'b0;
    end else if (!run) begin
      ivl_q     <= 20'h0_0000;
      acc_q     <= 20'h0_0000;
      corrAct_q <= 1'b0;
    end else if (slowTick) begin
      if (ivl_q == INTERVAL - 20'h0_0001) begin
        ivl_q     <= 20'h0_0000;
        acc_q     <= 20'h0_0000;
        corrAct_q <= corrOn;
      end else begin
        if (ivl_q == 20'h0_0000 && !corrAct_q) begin
          corrAct_q <= corrOn;
        end
        ivl_q <= ivl_q + 20'h0_0001;
        acc_q <= corrHit ? accSum - INTERVAL : accSum;
      end
    end
  end

endmodule // rpc_prescaler

// ---- src/rpc_top.v ----
/*
 * real-time counter with periodic tick, crystal correction, events,
 * two interrupt lines and write-crossing pending flags, on an apb slave.
 * assumes: all inputs synchronous to mclk; rtcClk is the slow clock
 * sampled as a level, at least four times slower than mclk.
 */
// The implementer's own choice: the APB slave port.
// Function
// - correction on makes the shared prescaler apply calibration ppm.
// - corrections are organised over a one-million-cycle interval.
// - each correction adds or drops one input cycle, by sign.
// - error count corrections per interval, spread by error value.
// - corrected timing shows in the count and in tick periods.
// - switching correction off lets the current interval finish.
// - enabled counter strobes wrap event for one slow cycle.
// - enabled counter strobes match event for one slow cycle.
// - eight tick events are square waves, 8192 down to 64 cycles.
// - counter irq shared by wrap and match; tick has its own.
// - tick irq condition each time the selected period elapses.
// - flags set on their condition regardless of enable.
// - irq asserted while enable and flag both set.
// - counter and tick keep separate enable and flag registers.
// - counter runs in idle; in standby only with run-in-standby.
// - tick runs in every sleep mode.
// - control and count writes apply after slow-domain crossing.
// - status shows compare, top, count and control pending flags.
// - tick status bit 0 pending while tick control crosses.
// - control a resets zero; standby 7, presc 6:3, corr 2, on 0.
// - prescaler divides by two to the field; applies two edges late.
// - sign 0 slows, sign 1 speeds the prescaler, needs div 2.
// - writing one clears a flag, zero leaves it.
// - wrap resets the count to zero.
`timescale 1ns/1ns
`include "rpc_defs.vh"

module rpc_top (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rtcClk,
  input  wire        sleepStandby,
  input  wire        debugHalt,
  output reg         wrapEvent,
  output reg         matchEvent,
  output reg  [7:0]  tickEvents,
  output reg         counterIrq,
  output reg         tickIrq
);

  // software-visible registers
  reg  [7:0]  control_a_q;
  reg  [1:0]  intEn_q;
  reg  [1:0]  flags_q;
  reg  [7:0]  temp_q;
  reg         run_when_halted_q;
  reg  [7:0]  trim_q;
  reg  [1:0]  clock_source_select_q;
  reg  [15:0] cntWr_q;
  reg  [15:0] top_q;
  reg  [15:0] cmp_q;
  reg  [7:0]  tCtrl_q;
  reg         tIntEn_q;
  reg         tFlag_q;
  reg         tDbgRun_q;
  // copies active in the slow domain
  reg  [7:0]  ctrlAct_q;
  reg  [15:0] topAct_q;
  reg  [15:0] cmpAct_q;
  reg  [7:0]  tCtrlAct_q;
  reg  [15:0] count_q;
  reg         rtcPrev_q;
  reg         tBitPrev_q;
  reg  [31:0] rdMux;

  wire        slowTick = rtcClk & ~rtcPrev_q;
  wire        apbDone  = psel & penable & pready;
  wire        wrEn     = apbDone & pwrite;
  wire [5:0]  idx      = paddr[7:2];
  wire [14:0] presc;
  wire        countStep;
  wire        pendCtrl;
  wire        pendCnt;
  wire        pendTop;
  wire        pendCmp;
  wire        pendTick;
  wire        applyCtrl;
  wire        applyCnt;
  wire        applyTop;
  wire        applyCmp;
  wire        applyTick;

  // register index is mapped
  function mapped;
    input [5:0] i;
    begin
      case (i)
        `RPC_IDX_CTL, `RPC_IDX_STATUS, `RPC_IDX_INTEN,
        `RPC_IDX_FLAGS, `RPC_IDX_TEMP, `RPC_IDX_DBG,
        `RPC_IDX_TRIM, `RPC_IDX_SRC, `RPC_IDX_COUNT,
        `RPC_IDX_TOP, `RPC_IDX_CMP, `RPC_IDX_TCTRL,
        `RPC_IDX_TSTATUS, `RPC_IDX_TINTEN, `RPC_IDX_TINTFLAGS,
        `RPC_IDX_TDBG: mapped = 1'b1;
        default:       mapped = 1'b0;
      endcase
    end
  endfunction

  // write strobe for one register index
  function wrHit;
    input       en;
    input [5:0] i;
    input [5:0] target;
    begin
      wrHit = en && (i == target);
    end
  endfunction

  // running conditions under sleep and debug halt
  wire counterRun = ctrlAct_q[`RPC_CA_ON]
                  & (~sleepStandby | ctrlAct_q[`RPC_CA_STDBY])
                  & (~debugHalt | run_when_halted_q);
  wire tickRun    = tCtrlAct_q[`RPC_TC_ON]
                  & (~debugHalt | tDbgRun_q);
  wire [3:0] tPer = tCtrlAct_q[`RPC_TC_PER_HI:`RPC_TC_PER_LO];
  wire tickBit    = (tPer != 4'hF) && (tPer != 4'h0) && presc[tPer];
  wire tickRise   = tickRun & tickBit & ~tBitPrev_q;
  wire stepNow    = slowTick & counterRun & countStep;
  wire atTop      = (count_q == topAct_q);
  wire atCmp      = (count_q == cmpAct_q);

  // shared prescaler with correction
  rpc_prescaler u_presc (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .slowTick  (slowTick),
    .run       (counterRun | tickRun),
    .corrOn    (ctrlAct_q[`RPC_CA_CORR]),
    .corrSign  (trim_q[`RPC_CAL_SIGN]),
    .corrErr   (trim_q[`RPC_CAL_ERR_HI:0]),
    .divSel    (ctrlAct_q[`RPC_CA_PRESC_HI:`RPC_CA_PRESC_LO]),
    .presc_q   (presc),
    .countStep (countStep)
  );

  // write crossings into the slow domain
  rpc_sync_slot u_syCtrl (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .load      (wrHit(wrEn, idx, `RPC_IDX_CTL)),
    .slowTick  (slowTick),
    .pending_q (pendCtrl),
    .apply_q   (applyCtrl)
  );

  rpc_sync_slot u_syCnt (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .load      (wrHit(wrEn, idx, `RPC_IDX_COUNT)),
    .slowTick  (slowTick),
    .pending_q (pendCnt),
    .apply_q   (applyCnt)
  );

  rpc_sync_slot u_syTop (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .load      (wrHit(wrEn, idx, `RPC_IDX_TOP)),
    .slowTick  (slowTick),
    .pending_q (pendTop),
    .apply_q   (applyTop)
  );

  rpc_sync_slot u_syCmp (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .load      (wrHit(wrEn, idx, `RPC_IDX_CMP)),
    .slowTick  (slowTick),
    .pending_q (pendCmp),
    .apply_q   (applyCmp)
  );

  rpc_sync_slot u_syTick (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .load      (wrHit(wrEn, idx, `RPC_IDX_TCTRL)),
    .slowTick  (slowTick),
    .pending_q (pendTick),
    .apply_q   (applyTick)
  );

  // read data selection
  always @* begin
    rdMux = 32'h0000_0000;
    case (idx)
      `RPC_IDX_CTL:       rdMux[7:0] = control_a_q;
      `RPC_IDX_STATUS:    rdMux[3:0] = {pendCmp, pendTop,
                                        pendCnt, pendCtrl};
      `RPC_IDX_INTEN:     rdMux[1:0] = intEn_q;
      `RPC_IDX_FLAGS:     rdMux[1:0] = flags_q;
      `RPC_IDX_TEMP:      rdMux[7:0] = temp_q;
      `RPC_IDX_DBG:       rdMux[0]   = run_when_halted_q;
      `RPC_IDX_TRIM:      rdMux[7:0] = trim_q;
      `RPC_IDX_SRC:       rdMux[1:0] = clock_source_select_q;
      `RPC_IDX_COUNT:     rdMux[15:0] = count_q;
      `RPC_IDX_TOP:       rdMux[15:0] = top_q;
      `RPC_IDX_CMP:       rdMux[15:0] = cmp_q;
      `RPC_IDX_TCTRL:     rdMux[7:0] = tCtrl_q;
      `RPC_IDX_TSTATUS:   rdMux[0]   = pendTick;
      `RPC_IDX_TINTEN:    rdMux[0]   = tIntEn_q;
      `RPC_IDX_TINTFLAGS: rdMux[0]   = tFlag_q;
      `RPC_IDX_TDBG:      rdMux[0]   = tDbgRun_q;
      default:            rdMux = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait cycle, then registered data and error
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped(idx);
      prdata  <= pwrite ? 32'h0000_0000 : rdMux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // plain software registers
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      control_a_q   <= `RPC_RST_8;
      intEn_q   <= 2'b00;
      temp_q    <= `RPC_RST_8;
      run_when_halted_q  <= 1'b0;
      trim_q    <= `RPC_RST_8;
      clock_source_select_q  <= 2'b00;
      cntWr_q   <= `RPC_RST_CNT;
      top_q     <= `RPC_RST_TOP;
      cmp_q     <= `RPC_RST_CMP;
      tCtrl_q   <= `RPC_RST_8;
      tIntEn_q  <= 1'b0;
      tDbgRun_q <= 1'b0;
    end else if (wrEn) begin
      case (idx)
        `RPC_IDX_CTL:    control_a_q   <= pwdata[7:0] & `RPC_CA_MASK;
        `RPC_IDX_INTEN:  intEn_q   <= pwdata[1:0];
        `RPC_IDX_TEMP:   temp_q    <= pwdata[7:0];
        `RPC_IDX_DBG:    run_when_halted_q  <= pwdata[0];
        `RPC_IDX_TRIM:   trim_q    <= pwdata[7:0];
        `RPC_IDX_SRC:    clock_source_select_q  <= pwdata[1:0];
        `RPC_IDX_COUNT:  cntWr_q   <= pwdata[15:0];
        `RPC_IDX_TOP:    top_q     <= pwdata[15:0];
        `RPC_IDX_CMP:    cmp_q     <= pwdata[15:0];
        `RPC_IDX_TCTRL:  tCtrl_q   <= pwdata[7:0] & `RPC_TC_MASK;
        `RPC_IDX_TINTEN: tIntEn_q  <= pwdata[0];
        `RPC_IDX_TDBG:   tDbgRun_q <= pwdata[0];
        default:         temp_q    <= temp_q;
      endcase
    end
  end

  // copies taken over once their crossing has finished
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlAct_q  <= `RPC_RST_8;
      topAct_q   <= `RPC_RST_TOP;
      cmpAct_q   <= `RPC_RST_CMP;
      tCtrlAct_q <= `RPC_RST_8;
    end else begin
      if (applyCtrl) ctrlAct_q  <= control_a_q;
      if (applyTop)  topAct_q   <= top_q;
      if (applyCmp)  cmpAct_q   <= cmp_q;
      if (applyTick) tCtrlAct_q <= tCtrl_q;
    end
  end

  // slow edge detect and tick bit history
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rtcPrev_q  <= 1'b0;
      tBitPrev_q <= 1'b0;
    end else begin
      rtcPrev_q  <= rtcClk;
      tBitPrev_q <= tickRun & tickBit;
    end
  end

  // counter: load from crossing, wrap at top, else count up
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= `RPC_RST_CNT;
    end else if (applyCnt) begin
      count_q <= cntWr_q;
    end else if (stepNow) begin
      count_q <= atTop ? 16'h0000 : count_q + 16'h0001;
    end
  end

  // event strobes held for one slow-clock cycle
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrapEvent  <= 1'b0;
      matchEvent <= 1'b0;
    end else if (slowTick) begin
      wrapEvent  <= stepNow & atTop;
      matchEvent <= stepNow & atCmp;
    end
  end

  // tick square-wave events from prescaler bits 12 down to 5
  always @(posedge mclk or posedge sys_rst) begin : tickEvt
    integer k;
    if (sys_rst) begin
      tickEvents <= 8'h00;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        tickEvents[k] <= tickRun & presc[`RPC_EVT_TOP_BIT - k];
      end
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= 2'b00;
      tFlag_q <= 1'b0;
    end else begin
      if (wrHit(wrEn, idx, `RPC_IDX_FLAGS)) begin
        flags_q <= flags_q & ~pwdata[1:0];
      end
      if (wrHit(wrEn, idx, `RPC_IDX_TINTFLAGS)) begin
        tFlag_q <= tFlag_q & ~pwdata[0];
      end
      if (stepNow && atTop) flags_q[`RPC_IRQ_WRAP]  <= 1'b1;
      if (stepNow && atCmp) flags_q[`RPC_IRQ_MATCH] <= 1'b1;
      if (tickRise) tFlag_q <= 1'b1;
    end
  end

  // interrupt lines: counter shares one, tick has its own
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      counterIrq <= 1'b0;
      tickIrq    <= 1'b0;
    end else begin
      counterIrq <= |(intEn_q & flags_q);
      tickIrq    <= tIntEn_q & tFlag_q;
    end
  end

endmodule // rpc_top

// ---- testbench/rpc_top_asserts.sv ----
/*
 * port checks for the counter and tick block.
 * assumes: bound to rpc_top; rtcClk is at least four times slower than
 * mclk and at most SLOW_MAX mclk cycles to a period.
 */
`timescale 1ns/1ns

module rpc_top_asserts (
  input logic        mclk,
  input logic        sys_rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        rtcClk,
  input logic        wrapEvent,
  input logic        matchEvent,
  input logic [7:0]  tickEvents,
  input logic        counterIrq,
  input logic        tickIrq
);
  localparam int SLOW_MAX = 40;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // decoded index and completed register writes
  wire [5:0] regIdx   = paddr[7:2];
  wire       isMapped = (regIdx <= 6'h08) || (regIdx == 6'h0A) ||
                        (regIdx == 6'h0C) || (regIdx == 6'h15) ||
                        (regIdx >= 6'h10 && regIdx <= 6'h13);
  wire       wrDone   = psel && penable && pready && pwrite;
  wire       cntClr   = wrDone && (regIdx == 6'h02 || regIdx == 6'h03);
  wire       tickClr  = wrDone && (regIdx == 6'h12 || regIdx == 6'h13);

  // raw slow-clock rises counted while the wrap strobe stands
  logic       rtcPrev_q;
  logic [2:0] wrapRises_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rtcPrev_q   <= 1'b0;
      wrapRises_q <= 3'd0;
    end else begin
      rtcPrev_q <= rtcClk;
      if (!wrapEvent)
        wrapRises_q <= 3'd0;
      else if (rtcClk && !rtcPrev_q)
        wrapRises_q <= wrapRises_q + 3'd1;
    end
  end

  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence apbAccess;
    psel && penable;
  endsequence

  AST_APB_WAIT: assert property (apbSetup ##1 apbAccess |=> pready)
    else $error("no answer one cycle into the access phase");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_ERR_UNMAPPED: assert property (pslverr |-> pready && !isMapped)
    else $error("slave error on a mapped index");
  AST_WRITE_NO_DATA: assert property (pready && pwrite |-> prdata == 0)
    else $error("read data not zero on a write");
  AST_WRAP_ONE_SLOW: assert property (
    $fell(wrapEvent) |-> wrapRises_q == 3'd1)
    else $error("wrap strobe not one slow cycle long");
  AST_WRAP_BOUNDED: assert property (
    $rose(wrapEvent) |-> ##[1:SLOW_MAX] !wrapEvent)
    else $error("wrap strobe never ends");
  AST_MATCH_SPAN: assert property (
    $rose(matchEvent) |-> matchEvent[*4] ##[1:SLOW_MAX] !matchEvent)
    else $error("match strobe length wrong");
  AST_TICK_CARRY5: assert property (
    $changed(tickEvents[5]) && $past(tickEvents) != 8'h00
      |-> tickEvents[7:6] == 2'b00)
    else $error("tick event 5 moved without carry from faster ones");
  AST_TICK_CARRY6: assert property (
    $rose(tickEvents[6]) && $past(tickEvents) != 8'h00
      |-> !tickEvents[7])
    else $error("tick event 6 rose without carry from event 7");
  AST_CNT_IRQ_HOLD: assert property (
    $fell(counterIrq) |-> $past(cntClr) || $past(cntClr, 2))
    else $error("counter irq dropped without a clear");
  AST_TICK_IRQ_HOLD: assert property (
    $fell(tickIrq) |-> $past(tickClr) || $past(tickClr, 2))
    else $error("tick irq dropped without a clear");
endmodule // rpc_top_asserts

bind rpc_top rpc_top_asserts rpc_top_asserts_inst (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rtcClk(rtcClk), .wrapEvent(wrapEvent),
  .matchEvent(matchEvent), .tickEvents(tickEvents),
  .counterIrq(counterIrq), .tickIrq(tickIrq)
);

// ---- testbench/tb_rpc_top.sv ----
/*
 * self-checking bench for the counter and tick block over apb.
 * assumes: rpc_top with its checker bound; the bench makes the slow
 * clock from mclk at one eighth of its rate.
 */
`timescale 1ns/1ns

module tb_rpc_top;
  logic        mclk, sys_rst, psel, penable, pwrite, er;
  logic [7:0]  paddr, tickEvents;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rtcClk, sleepStandby, debugHalt;
  logic        wrapEvent, matchEvent, counterIrq, tickIrq;
  logic [1:0]  slowDiv_q;
  int          nFail, checkCount, i;
  time         t0, t1;
  logic [5:0]  mapIdx [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h07, 6'h08, 6'h0A, 6'h0C, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
  logic [5:0]  syIdx [4] = '{6'h0A, 6'h0C, 6'h08, 6'h00};
  logic [7:0]  syVal [4] = '{8'h03, 8'h01, 8'h02, 8'hFF};
  logic [7:0]  syExp [4] = '{8'h03, 8'h01, 8'h02, 8'hFD};
  int          syBit [4] = '{2, 3, 1, 0};

  rpc_top rpc_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtcClk(rtcClk),
    .sleepStandby(sleepStandby), .debugHalt(debugHalt),
    .wrapEvent(wrapEvent), .matchEvent(matchEvent),
    .tickEvents(tickEvents), .counterIrq(counterIrq), .tickIrq(tickIrq)
  );

  // system clock, 100 ns period
  always #50 mclk = ~mclk;

  // slow clock at one eighth of mclk, moved just after mclk edges
  always @(posedge mclk) begin
    slowDiv_q <= slowDiv_q + 2'd1;
    if (slowDiv_q == 2'd3)
      rtcClk <= ~rtcClk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      nFail++;
    end
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nFail++;
      results();
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic chk(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    cmp($sformatf("register %h", idx), exp, rd);
  endtask

  // poll a status register until every pending bit has cleared
  task automatic waitSync(input logic [5:0] idx);
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 32'h0000_0000);
      n++;
    end while (rd !== 32'h0000_0000 && n < 40);
    if (rd !== 32'h0000_0000) begin
      nFail++;
      results();
    end
  endtask

  function automatic logic probe(input logic [3:0] s);
    return (s == 4'd8) ? wrapEvent :
           (s == 4'd9) ? tickIrq : tickEvents[s[2:0]];
  endfunction

  // time of the next rise of a watched output, zero if none came
  task automatic waitRise(input logic [3:0] s, input bit must, output time t);
    int n;
    n = 0;
    while (probe(s) !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    while (probe(s) !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    t = (probe(s) === 1'b1) ? $time : 0;
    if (must && t == 0) begin
      nFail++;
      results();
    end
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rtcClk, slowDiv_q, sleepStandby, debugHalt} = '0;
    nFail = 0;
    checkCount = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (mapIdx[k])
      chk(mapIdx[k], (mapIdx[k] == 6'h0A) ? 32'h0000_FFFF : 0);
    // reserved places answer with an error and read zero
    apb(1'b1, 6'h0E, 32'h0000_00FF);
    cmp("write error", 1, {31'h0, er});
    apb(1'b0, 6'h14, 32'h0000_0000);
    cmp("read error", 1, {31'h0, er});
    cmp("reserved data", 0, rd);
    // each crossing write shows its pending bit until applied
    for (i = 0; i < 4; i++) begin
      wr(syIdx[i], {24'h0, syVal[i]});
      chk(6'h01, 32'h1 << syBit[i]);
      waitSync(6'h01);
      chk(syIdx[i], {24'h0, syExp[i]});
    end
    wr(6'h10, 32'h0000_0011);
    chk(6'h11, 32'h1);
    waitSync(6'h11);
    chk(6'h10, 32'h0000_0011);
    wr(6'h06, 32'h0000_0085);
    chk(6'h06, 32'h0000_0085);
    // tick flag sets with its enable low
    waitRise(4'd7, 1'b1, t0);
    chk(6'h13, 32'h1);
    cmp("tick irq", 0, {31'h0, tickIrq});
    // wrap spacing follows top and the prescaler divide
    for (i = 0; i < 3; i++) begin
      wr(6'h00, (i << 3) | 1);
      waitSync(6'h01);
      waitRise(4'd8, 1'b1, t0);
      waitRise(4'd8, 1'b1, t1);
      cmp("wrap spacing", 32'd3200 << i, 32'(t1 - t0));
    end
    chk(6'h03, 32'h3);
    cmp("counter irq", 0, {31'h0, counterIrq});
    wr(6'h02, 32'h1);
    chk(6'h02, 32'h1);
    cmp("counter irq", 1, {31'h0, counterIrq});
    wr(6'h00, 32'h0);
    waitSync(6'h01);
    wr(6'h03, 32'h2);
    chk(6'h03, 32'h1);
    cmp("counter irq", 1, {31'h0, counterIrq});
    wr(6'h03, 32'h1);
    chk(6'h03, 32'h0);
    cmp("counter irq", 0, {31'h0, counterIrq});
    // standby halts the counter unless it may run there; tick runs on
    sleepStandby <= 1'b1;
    wr(6'h00, 32'h1);
    waitSync(6'h01);
    waitRise(4'd8, 1'b0, t0);
    cmp("standby halt", 0, 32'(t0));
    waitRise(4'd7, 1'b1, t0);
    cmp("tick in standby", 1, {31'h0, t0 != 0});
    wr(6'h00, 32'h0000_0081);
    waitSync(6'h01);
    waitRise(4'd8, 1'b0, t0);
    cmp("standby run", 1, {31'h0, t0 != 0});
    sleepStandby <= 1'b0;
    // tick events 7 and 6 run at 64 and 128 slow cycles
    for (i = 7; i > 5; i--) begin
      waitRise(i[3:0], 1'b1, t0);
      waitRise(i[3:0], 1'b1, t1);
      cmp("tick period", 32'd51200 << (7 - i), 32'(t1 - t0));
    end
    // tick irq comes back every selected period
    wr(6'h12, 32'h1);
    chk(6'h12, 32'h1);
    cmp("tick irq", 1, {31'h0, tickIrq});
    wr(6'h13, 32'h1);
    waitRise(4'd9, 1'b1, t0);
    wr(6'h13, 32'h1);
    waitRise(4'd9, 1'b1, t1);
    cmp("tick irq spacing", 32'd6400, 32'(t1 - t0));
    // debug halt stops the tick unless it may run there
    debugHalt <= 1'b1;
    waitRise(4'd7, 1'b0, t0);
    cmp("tick in debug halt", 0, 32'(t0));
    wr(6'h15, 32'h1);
    chk(6'h15, 32'h1);
    waitRise(4'd7, 1'b0, t0);
    cmp("tick debug run", 1, {31'h0, t0 != 0});
    results();
  end
endmodule // tb_rpc_top
